// >>> design/uart_rx_special.sv
`include "uart_rx_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Address filter in 9-bit mode drops words with ninth bit zero, no interrupt.
// - Wake-on-break waits for high line after break, never restarts on break.
// - Break loads all-zero word with framing error; nothing more until line high.
// - Wake enable clears itself when line goes high after the break.
// - Receiver idle flag rises once the line returns high after a break.
// - Character length follows format and stop selects; long break completes then.
// - Without wake, break is one ordinary all-zero word with framing error.
// - Transmit enable sets only when module enable is already set.
// - Loopback feeds transmit output to receiver, ignores receive pin, keeps tx pin.
// - In loopback, pin-usage field selects handshake or baud clock pin functions.
// - Auto-baud starts on start bit, only with wake and loopback both clear.
// - Setting auto-baud clears the baud counter, then waits fall then rise.
// - Counter runs at clock/8 from start end; fifth rise loads divisor, clears enable.
// - Auto-baud holds receiver idle, FIFO untouched, interrupt flag set at fifth rise.
// - Wake has priority; auto-baud then runs on character after the break.
// - Interrupt threshold: 0x every word, 10 at 3 or 4 words, 11 when full.
// - Address filter has no effect in 8-bit data mode.
module uart_rx_special #(
  parameter int DIV_W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialInPin,
  input wire logic txSerial,
  input wire logic ctsPinIn,
  output logic serialOutPin,
  output logic rtsPinOut,
  output logic rtsPinOe,
  output logic ctsToTx,
  output logic baudClkOut,
  output logic baudClkOe,
  output logic txEnable,
  output logic rxIrqFlag
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW:0] THREE = (PW+1)'(3);

  // ==========================================================
  // Line sampling and loopback
  logic rxLine_ff, rxPrev_ff;
  uart_rx_pkg::mode_t mode_ff, nxt_mode;
  logic fall, rise;
  assign fall = rxPrev_ff & ~rxLine_ff;
  assign rise = ~rxPrev_ff & rxLine_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxLine_ff <= 1'b1;
      rxPrev_ff <= 1'b1;
    end else begin
      rxLine_ff <= mode_ff.loopback ? txSerial : serialInPin;
      rxPrev_ff <= rxLine_ff;
    end
  end

  // ==========================================================
  // Register state
  logic [1:0] thr_ff, nxt_thr;
  logic addrFilter_ff, nxt_addrFilter;
  logic txEn_ff, nxt_txEn;
  logic irq_ff, nxt_irq;
  logic oerr_ff, nxt_oerr;
  logic [DIV_W-1:0] baudDiv_ff, nxt_baudDiv;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;

  // ==========================================================
  // Receiver state
  uart_rx_pkg::rx_state_t st_ff, nxt_st;
  logic [DIV_W-1:0] divCnt_ff, nxt_divCnt;
  logic [3:0] sub_ff, nxt_sub, bit_ff, nxt_bit;
  logic [8:0] shift_ff, nxt_shift;
  logic stopErr_ff, nxt_stopErr;
  logic [2:0] pre_ff, nxt_pre, edges_ff, nxt_edges;
  logic [DIV_W-1:0] abdCnt_ff, nxt_abdCnt;
  logic idle_ff, nxt_idle;
  logic push, abdDone, wakeClr;
  uart_rx_pkg::rx_word_t pushWord;

  // ==========================================================
  // FIFO state
  uart_rx_pkg::rx_word_t mem_ff [DEPTH];
  logic [PW-1:0] wrPtr_ff, rdPtr_ff;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic doPush, pop, fifoReset;

  logic access, done, wrMode, wrStat, rdData, abaudSet;
  assign access = psel & penable;
  assign done = access & pready_ff;
  assign wrMode = done & pwrite & (paddr == `ADDR_MODE);
  assign wrStat = done & pwrite & (paddr == `ADDR_STAT);
  assign rdData = done & ~pwrite & (paddr == `ADDR_RXDATA);
  assign abaudSet = wrMode & pwdata[`MODE_AUTOBAUD_ENABLE_BIT] & ~mode_ff.autobaud;

  logic tick, sampleNow, bitEnd, nine;
  logic [3:0] lastBit, lastStop;
  logic [8:0] word;
  assign tick = (divCnt_ff == baudDiv_ff);
  assign sampleNow = tick & (sub_ff == `SUB_MID);
  assign bitEnd = tick & (sub_ff == `SUB_LAST);
  assign nine = (mode_ff.dataFormat == `FMT_NINE);
  // Parity formats add one bit; it is counted but not checked here
  assign lastBit = (mode_ff.dataFormat == `FMT_EIGHT) ? `LAST_BIT_EIGHT : `LAST_BIT_NINE;
  assign lastStop = mode_ff.stopCount ? 4'h1 : 4'h0;
  always_comb begin
    unique case (mode_ff.dataFormat)
      `FMT_EIGHT: word = {1'b0, shift_ff[8:1]};
      `FMT_NINE: word = shift_ff;
      default: word = {1'b0, shift_ff[7:0]};
    endcase
  end

  // ==========================================================
  // Receive sequencer and auto-baud measurement
  always_comb begin
    nxt_st = st_ff;
    nxt_divCnt = tick ? '0 : divCnt_ff + 1'b1;
    nxt_sub = tick ? sub_ff + 4'h1 : sub_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_stopErr = stopErr_ff;
    nxt_pre = pre_ff;
    nxt_edges = edges_ff;
    nxt_abdCnt = abaudSet ? '0 : abdCnt_ff;
    push = 1'b0;
    abdDone = 1'b0;
    wakeClr = 1'b0;
    pushWord = '{framing_error_flag: stopErr_ff, data: word};
    unique case (st_ff)
      uart_rx_pkg::RX_IDLE: begin
        // Wake blocks auto-baud, so it waits for the character after the break
        if (mode_ff.autobaud & ~mode_ff.wake & ~mode_ff.loopback) begin
          nxt_st = uart_rx_pkg::ABD_FALL;
        end else if (mode_ff.moduleEnable & fall) begin
          nxt_st = uart_rx_pkg::RX_START;
          nxt_divCnt = '0;
          nxt_sub = 4'h0;
        end
      end
      uart_rx_pkg::RX_START: begin
        if (sampleNow & rxLine_ff) begin
          nxt_st = uart_rx_pkg::RX_IDLE;
        end else if (bitEnd) begin
          nxt_st = uart_rx_pkg::RX_BITS;
          nxt_bit = 4'h0;
        end
      end
      uart_rx_pkg::RX_BITS: begin
        if (sampleNow) begin
          nxt_shift = {rxLine_ff, shift_ff[8:1]};
        end
        if (bitEnd) begin
          nxt_bit = bit_ff + 4'h1;
          if (bit_ff == lastBit) begin
            nxt_st = uart_rx_pkg::RX_STOP;
            nxt_bit = 4'h0;
          end
        end
      end
      uart_rx_pkg::RX_STOP: begin
        if (sampleNow & (bit_ff == 4'h0)) begin
          nxt_stopErr = ~rxLine_ff;
        end
        if (bitEnd) begin
          nxt_bit = bit_ff + 4'h1;
          if (bit_ff == lastStop) begin
            // Break or not, the word is buffered with its framing flag unless the address filter drops it
            push = ~(addrFilter_ff & nine & ~word[8]);
            // A low first stop bit waits for the line to recover first
            nxt_st = stopErr_ff ? uart_rx_pkg::RX_WAITHI : uart_rx_pkg::RX_IDLE;
          end
        end
      end
      uart_rx_pkg::RX_WAITHI: begin
        if (rxLine_ff) begin
          nxt_st = uart_rx_pkg::RX_IDLE;
          wakeClr = mode_ff.wake;
        end
      end
      uart_rx_pkg::ABD_FALL: begin
        if (!mode_ff.autobaud) begin
          nxt_st = uart_rx_pkg::RX_IDLE;
        end else if (fall) begin
          nxt_st = uart_rx_pkg::ABD_RISE;
        end
      end
      uart_rx_pkg::ABD_RISE: begin
        if (!mode_ff.autobaud) begin
          nxt_st = uart_rx_pkg::RX_IDLE;
        end else if (rise) begin
          nxt_st = uart_rx_pkg::ABD_COUNT;
          nxt_edges = 3'h0;
          nxt_pre = 3'h0;
          nxt_abdCnt = '0;
        end
      end
      uart_rx_pkg::ABD_COUNT: begin
        nxt_pre = pre_ff + 3'h1;
        if (pre_ff == `ABD_PRESCALE_LAST) begin
          nxt_abdCnt = abdCnt_ff + 1'b1;
        end
        if (!mode_ff.autobaud) begin
          nxt_st = uart_rx_pkg::RX_IDLE;
        end else if (rise) begin
          nxt_edges = edges_ff + 3'h1;
          if (edges_ff == `ABD_LAST_EDGE - 3'h1) begin
            abdDone = 1'b1;
            nxt_st = uart_rx_pkg::RX_IDLE;
          end
        end
      end
    endcase
    // Auto-baud states decode as idle, so the receiver still reports idle
    nxt_idle = (nxt_st inside {uart_rx_pkg::RX_IDLE, uart_rx_pkg::ABD_FALL,
                               uart_rx_pkg::ABD_RISE, uart_rx_pkg::ABD_COUNT});
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= uart_rx_pkg::RX_IDLE;
      divCnt_ff <= '0;
      sub_ff <= 4'h0;
      bit_ff <= 4'h0;
      shift_ff <= 9'h000;
      stopErr_ff <= 1'b0;
      pre_ff <= 3'h0;
      edges_ff <= 3'h0;
      abdCnt_ff <= '0;
      idle_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      divCnt_ff <= nxt_divCnt;
      sub_ff <= nxt_sub;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      stopErr_ff <= nxt_stopErr;
      pre_ff <= nxt_pre;
      edges_ff <= nxt_edges;
      abdCnt_ff <= nxt_abdCnt;
      idle_ff <= nxt_idle;
    end
  end

  // ==========================================================
  // Receive FIFO; clearing overrun discards its contents
  logic [PW:0] after;
  logic irqSet;
  assign fifoReset = wrStat & ~pwdata[`STAT_OERR_BIT] & oerr_ff;
  assign pop = rdData & (cnt_ff != '0);
  assign doPush = push & ~oerr_ff & (cnt_ff != FULL);
  assign after = cnt_ff + (PW+1)'(doPush) - (PW+1)'(pop);
  always_comb begin
    nxt_cnt = fifoReset ? '0 : after;
    nxt_oerr = (push & ~oerr_ff & (cnt_ff == FULL)) | (oerr_ff & ~fifoReset);
    unique case (thr_ff)
      `THR_THREE: irqSet = doPush & (after >= THREE);
      `THR_FULL: irqSet = doPush & (after == FULL);
      default: irqSet = doPush;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff <= '0;
      oerr_ff <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      cnt_ff <= nxt_cnt;
      oerr_ff <= nxt_oerr;
      if (doPush) begin
        mem_ff[wrPtr_ff] <= pushWord;
      end
      wrPtr_ff <= fifoReset ? '0 : wrPtr_ff + PW'(doPush);
      rdPtr_ff <= fifoReset ? '0 : rdPtr_ff + PW'(pop);
    end
  end

  // ==========================================================
  // APB registers; one wait state on every access
  uart_rx_pkg::rx_word_t top;
  assign top = mem_ff[rdPtr_ff];
  always_comb begin
    nxt_mode = mode_ff;
    nxt_thr = thr_ff;
    nxt_addrFilter = addrFilter_ff;
    nxt_txEn = txEn_ff;
    nxt_baudDiv = abdDone ? abdCnt_ff : baudDiv_ff;
    nxt_pready = access & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    if (wakeClr) nxt_mode.wake = 1'b0;
    if (abdDone) nxt_mode.autobaud = 1'b0;
    if (wrMode) begin
      nxt_mode = '{moduleEnable: pwdata[`MODE_EN_BIT],
                   pinUsage: pwdata[`MODE_PINU_LSB+:2], wake: pwdata[`MODE_WAKE_BIT],
                   loopback: pwdata[`MODE_LPBK_BIT], autobaud: pwdata[`MODE_AUTOBAUD_ENABLE_BIT],
                   dataFormat: pwdata[`MODE_FMT_LSB+:2], stopCount: pwdata[`MODE_STOP_BIT]};
    end
    if (wrStat) begin
      nxt_thr = pwdata[`STAT_THR_LSB+:2];
      nxt_addrFilter = pwdata[`STAT_ADDR_BIT];
      nxt_txEn = pwdata[`STAT_TXEN_BIT] & mode_ff.moduleEnable;
    end
    if (!mode_ff.moduleEnable) nxt_txEn = 1'b0;
    if (done & pwrite & (paddr == `ADDR_BAUD)) nxt_baudDiv = pwdata[DIV_W-1:0];
    // Hardware set wins over a software clear in the same cycle
    nxt_irq = (irq_ff & ~(wrStat & pwdata[`STAT_IRQ_BIT])) | irqSet | abdDone;
    if (access & ~pready_ff) begin
      unique case (paddr)
        `ADDR_MODE: begin
          nxt_prdata[`MODE_EN_BIT] = mode_ff.moduleEnable;
          nxt_prdata[`MODE_PINU_LSB+:2] = mode_ff.pinUsage;
          nxt_prdata[`MODE_WAKE_BIT] = mode_ff.wake;
          nxt_prdata[`MODE_LPBK_BIT] = mode_ff.loopback;
          nxt_prdata[`MODE_AUTOBAUD_ENABLE_BIT] = mode_ff.autobaud;
          nxt_prdata[`MODE_FMT_LSB+:2] = mode_ff.dataFormat;
          nxt_prdata[`MODE_STOP_BIT] = mode_ff.stopCount;
        end
        `ADDR_STAT: begin
          nxt_prdata[`STAT_TXEN_BIT] = txEn_ff;
          nxt_prdata[`STAT_IRQ_BIT] = irq_ff;
          nxt_prdata[`STAT_THR_LSB+:2] = thr_ff;
          nxt_prdata[`STAT_ADDR_BIT] = addrFilter_ff;
          nxt_prdata[`STAT_IDLE_BIT] = idle_ff;
          nxt_prdata[`STAT_FRAMING_ERROR_FLAG_BIT] = (cnt_ff != '0) & top.framing_error_flag;
          nxt_prdata[`STAT_OERR_BIT] = oerr_ff;
          nxt_prdata[`STAT_AVAIL_BIT] = (cnt_ff != '0);
        end
        `ADDR_BAUD: nxt_prdata[DIV_W-1:0] = baudDiv_ff;
        `ADDR_RXDATA: nxt_prdata[9:0] = (cnt_ff != '0) ? top : '0;
        default: nxt_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= '0;
      thr_ff <= 2'h0;
      addrFilter_ff <= 1'b0;
      txEn_ff <= 1'b0;
      irq_ff <= 1'b0;
      baudDiv_ff <= `BAUD_RESET;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      thr_ff <= nxt_thr;
      addrFilter_ff <= nxt_addrFilter;
      txEn_ff <= nxt_txEn;
      irq_ff <= nxt_irq;
      baudDiv_ff <= nxt_baudDiv;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ==========================================================
  // Pin functions
  logic [1:0] pu;
  assign pu = mode_ff.pinUsage;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialOutPin <= 1'b1;
      rtsPinOut <= 1'b1;
      rtsPinOe <= 1'b0;
      ctsToTx <= 1'b0;
      baudClkOut <= 1'b0;
      baudClkOe <= 1'b0;
    end else begin
      serialOutPin <= txSerial;
      // Request to send is low while the receiver can take a word
      rtsPinOut <= (cnt_ff == FULL) | oerr_ff;
      rtsPinOe <= (pu == `PIN_RTS) | (pu == `PIN_RTSCTS);
      ctsToTx <= (pu == `PIN_RTSCTS) & (mode_ff.loopback ? rtsPinOut : ctsPinIn);
      baudClkOut <= (pu == `PIN_BCLK) & tick;
      baudClkOe <= (pu == `PIN_BCLK);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign txEnable = txEn_ff;
  assign rxIrqFlag = irq_ff;
endmodule
`default_nettype wire

// >>> design/uart_rx_cfg.svh
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH
// ==========================================================
// Register map
`define ADDR_MODE 12'h000
`define ADDR_STAT 12'h004
`define ADDR_BAUD 12'h008
`define ADDR_RXDATA 12'h00c
// ==========================================================
// Mode register fields
`define MODE_EN_BIT 15
`define MODE_PINU_LSB 8
`define MODE_WAKE_BIT 7
`define MODE_LPBK_BIT 6
`define MODE_AUTOBAUD_ENABLE_BIT 5
`define MODE_FMT_LSB 1
`define MODE_STOP_BIT 0
// ==========================================================
// Status register fields
`define STAT_TXEN_BIT 10
`define STAT_IRQ_BIT 9
`define STAT_THR_LSB 6
`define STAT_ADDR_BIT 5
`define STAT_IDLE_BIT 4
`define STAT_FRAMING_ERROR_FLAG_BIT 2
`define STAT_OERR_BIT 1
`define STAT_AVAIL_BIT 0
// ==========================================================
// Encodings, reset values and counts
`define FMT_EIGHT 2'h0
`define FMT_NINE 2'h3
`define THR_THREE 2'h2
`define THR_FULL 2'h3
`define PIN_RTS 2'h1
`define PIN_RTSCTS 2'h2
`define PIN_BCLK 2'h3
`define BAUD_RESET 16'h0000
`define SUB_LAST 4'hf
`define SUB_MID 4'h7
`define LAST_BIT_EIGHT 4'h7
`define LAST_BIT_NINE 4'h8
`define ABD_PRESCALE_LAST 3'h7
`define ABD_LAST_EDGE 3'h4
`endif

// >>> design/uart_rx_pkg.sv
package uart_rx_pkg;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_BITS = 3'b010,
    RX_STOP = 3'b011,
    RX_WAITHI = 3'b100,
    ABD_FALL = 3'b101,
    ABD_RISE = 3'b110,
    ABD_COUNT = 3'b111
  } rx_state_t;

  typedef struct packed {
    logic framing_error_flag;
    logic [8:0] data;
  } rx_word_t;

  typedef struct packed {
    logic moduleEnable;
    logic [1:0] pinUsage;
    logic wake;
    logic loopback;
    logic autobaud;
    logic [1:0] dataFormat;
    logic stopCount;
  } mode_t;
endpackage

// >>> test/uart_rx_special_asserts.sv
`include "uart_rx_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module uart_rx_special_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txSerial,
  input wire logic serialOutPin,
  input wire logic rtsPinOe,
  input wire logic ctsToTx,
  input wire logic baudClkOut,
  input wire logic baudClkOe,
  input wire logic txEnable,
  input wire logic rxIrqFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic statWr;
  assign statWr = pready && pwrite && paddr == `ADDR_STAT;
  // ====
  // Bus handshake, exactly one wait state
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_APB_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("stray ready");
  AST_APB_ERR: assert property (pready |->
      pslverr == !(paddr inside {`ADDR_MODE, `ADDR_STAT, `ADDR_BAUD, `ADDR_RXDATA}))
    else $error("bad slverr");
  // ====
  // Pins and flags
  AST_TX_ECHO: assert property (1'b1 |=> serialOutPin == $past(txSerial))
    else $error("tx pin not echoed");
  AST_PIN_EXCL: assert property (!(rtsPinOe && baudClkOe))
    else $error("pin functions clash");
  AST_BCLK_OE: assert property (baudClkOut |-> baudClkOe)
    else $error("baud clock undriven");
  // Both pin decodes are registered on the same edge
  AST_CTS_OE: assert property (ctsToTx |-> rtsPinOe)
    else $error("cts without rts mode");
  AST_TXEN_SET: assert property ($rose(txEnable) |-> $past(statWr && pwdata[`STAT_TXEN_BIT]))
    else $error("tx enable rose alone");
  AST_IRQ_CLR: assert property ($fell(rxIrqFlag) |-> $past(statWr && pwdata[`STAT_IRQ_BIT]))
    else $error("irq flag not sticky");
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property ($fell(rxIrqFlag));
  COV_BCLK: cover property (baudClkOut);
endmodule
bind uart_rx_special uart_rx_special_asserts i_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .txSerial(txSerial), .serialOutPin(serialOutPin), .rtsPinOe(rtsPinOe),
  .ctsToTx(ctsToTx), .baudClkOut(baudClkOut), .baudClkOe(baudClkOe), .txEnable(txEnable),
  .rxIrqFlag(rxIrqFlag));
`default_nettype wire

// >>> test/uart_station.sv
`timescale 1ns/100ps
`default_nettype none
module uart_station (
  input wire logic clk,
  output logic line
);
  // ====
  // Remote station, idle high
  initial line = 1'b1;
  // Start low, data LSB first, then stop and idle
  task automatic send(input logic [8:0] w, input int nd, input int bt);
    int k;
    line <= 1'b0;
    repeat (bt) @(posedge clk);
    for (k = 0; k < nd; k++) begin
      line <= w[k];
      repeat (bt) @(posedge clk);
    end
    line <= 1'b1;
    repeat (3 * bt) @(posedge clk);
  endtask
  // Break: line low for n clocks, then stop level
  task automatic hold_low(input int n);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
    repeat (32) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> test/uart_rx_special_test.sv
`include "uart_rx_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module uart_rx_special_test;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic serialInPin, txSerial, ctsPinIn, serialOutPin, rtsPinOut, rtsPinOe;
  logic ctsToTx, baudClkOut, baudClkOe, txEnable, rxIrqFlag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int bad_count, n_tests, i;
  uart_rx_special i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialInPin(serialInPin), .txSerial(txSerial), .ctsPinIn(ctsPinIn),
    .serialOutPin(serialOutPin), .rtsPinOut(rtsPinOut), .rtsPinOe(rtsPinOe),
    .ctsToTx(ctsToTx), .baudClkOut(baudClkOut), .baudClkOe(baudClkOe),
    .txEnable(txEnable), .rxIrqFlag(rxIrqFlag));
  uart_station i_rem (.clk(clk), .line(serialInPin));
  uart_station i_tx (.clk(clk), .line(txSerial));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ====
  // Tasks
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Holds the request until pready; only the watchdog ends a hang
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(s, e, q);
  endtask
  task automatic bit_chk(input string s, input logic [11:0] a, input int b, input logic e);
    apb(a, 1'b0, 32'h0);
    chk(s, {31'h0, e}, {31'h0, q[b]});
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  // ====
  // Tests
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ctsPinIn = 1'b1;
    bad_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk("mode", `ADDR_MODE, 32'h0);
    chk("no slverr", 32'h0, {31'h0, err});
    rd_chk("baud", `ADDR_BAUD, {16'h0, `BAUD_RESET});
    rd_chk("unmapped", 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(`ADDR_STAT, 1'b1, 32'h400);
    bit_chk("txen early", `ADDR_STAT, `STAT_TXEN_BIT, 1'b0);
    apb(`ADDR_MODE, 1'b1, 32'h8000);
    apb(`ADDR_STAT, 1'b1, 32'h420);
    bit_chk("txen", `ADDR_STAT, `STAT_TXEN_BIT, 1'b1);
    chk("txen pin", 32'h1, {31'h0, txEnable});
    i_rem.send(9'h0a5, 8, 16);
    chk("irq 8bit", 32'h1, {31'h0, rxIrqFlag});
    rd_chk("word 8bit", `ADDR_RXDATA, 32'h0a5);
    apb(`ADDR_STAT, 1'b1, 32'h620);
    apb(`ADDR_MODE, 1'b1, 32'h8006);
    i_rem.send(9'h055, 9, 16);
    chk("irq drop", 32'h0, {31'h0, rxIrqFlag});
    bit_chk("avail drop", `ADDR_STAT, `STAT_AVAIL_BIT, 1'b0);
    i_rem.send(9'h1aa, 9, 16);
    chk("irq addr", 32'h1, {31'h0, rxIrqFlag});
    rd_chk("addr word", `ADDR_RXDATA, 32'h1aa);
    // Filter off, interrupt only at fill level three, then full
    for (i = 2; i < 4; i++) begin
      apb(`ADDR_STAT, 1'b1, 32'h600 | (i << 6));
      repeat (i) i_rem.send(9'h0f0, 9, 16);
      chk("irq early", 32'h0, {31'h0, rxIrqFlag});
      i_rem.send(9'h00f, 9, 16);
      chk("irq level", 32'h1, {31'h0, rxIrqFlag});
      repeat (i + 1) apb(`ADDR_RXDATA, 1'b0, 32'h0);
    end
    apb(`ADDR_MODE, 1'b1, 32'h8000);
    apb(`ADDR_STAT, 1'b1, 32'h600);
    i_rem.hold_low(20 * 16);
    bit_chk("framing_error_flag", `ADDR_STAT, `STAT_FRAMING_ERROR_FLAG_BIT, 1'b1);
    rd_chk("brk word", `ADDR_RXDATA, 32'h200);
    bit_chk("brk once", `ADDR_STAT, `STAT_AVAIL_BIT, 1'b0);
    apb(`ADDR_MODE, 1'b1, 32'h80a0);
    apb(`ADDR_STAT, 1'b1, 32'h600);
    fork
      i_rem.hold_low(20 * 16);
      begin
        repeat (15 * 16) @(posedge clk);
        chk("brk irq", 32'h1, {31'h0, rxIrqFlag});
        bit_chk("wake held", `ADDR_MODE, `MODE_WAKE_BIT, 1'b1);
      end
    join
    bit_chk("wake off", `ADDR_MODE, `MODE_WAKE_BIT, 1'b0);
    bit_chk("idle", `ADDR_STAT, `STAT_IDLE_BIT, 1'b1);
    bit_chk("framing_error_flag wake", `ADDR_STAT, `STAT_FRAMING_ERROR_FLAG_BIT, 1'b1);
    bit_chk("abd held", `ADDR_MODE, `MODE_AUTOBAUD_ENABLE_BIT, 1'b1);
    apb(`ADDR_STAT, 1'b1, 32'h6c0);
    i_rem.send(9'h055, 8, 64);
    chk("abd irq", 32'h1, {31'h0, rxIrqFlag});
    bit_chk("abd off", `ADDR_MODE, `MODE_AUTOBAUD_ENABLE_BIT, 1'b0);
    apb(`ADDR_BAUD, 1'b0, 32'h0);
    chk("baud count", 32'h1, {31'h0, q >= 63 && q <= 65});
    rd_chk("wake word", `ADDR_RXDATA, 32'h200);
    bit_chk("fifo kept", `ADDR_STAT, `STAT_AVAIL_BIT, 1'b0);
    apb(`ADDR_BAUD, 1'b1, 32'h0);
    apb(`ADDR_STAT, 1'b1, 32'h600);
    for (i = 0; i < 4; i++) begin
      apb(`ADDR_MODE, 1'b1, 32'h8040 | (i << 8));
      bit_chk("lpbk", `ADDR_MODE, `MODE_LPBK_BIT, 1'b1);
      chk("rts oe", {31'h0, i == 1 || i == 2}, {31'h0, rtsPinOe});
      chk("bclk oe", {31'h0, i == 3}, {31'h0, baudClkOe});
      chk("rts", 32'h0, {31'h0, rtsPinOut});
      chk("cts fed", 32'h0, {31'h0, ctsToTx});
    end
    i_rem.send(9'h00f, 8, 16);
    bit_chk("pin cut", `ADDR_STAT, `STAT_AVAIL_BIT, 1'b0);
    i_tx.send(9'h03c, 8, 16);
    rd_chk("loop word", `ADDR_RXDATA, 32'h03c);
    apb(`ADDR_MODE, 1'b1, 32'h8200);
    bit_chk("lpbk off", `ADDR_MODE, `MODE_LPBK_BIT, 1'b0);
    chk("cts pin", 32'h1, {31'h0, ctsToTx});
    close_out();
  end
endmodule
`default_nettype wire
